// >>> dma_channel_ctrl.sv
// dma channel controller with descriptor memory, two queues and two transfer controllers
//
// Behaviour
// - 64 event channels, 8 quick channels
// - 128 descriptor sets of eight words
// - sets 0-63: event, quick or link; sets 64-127: quick or link
// - single mode: one array per event
// - two-dim mode: full frame per event
// - software set bit triggers channel
// - quick trigger word write submits immediately
// - quick channel set pointer is programmable
// - descriptor memory writable over config port
// - events latch even when disabled
// - each channel except 8, 9 and the reserved ones has one fixed source
// - select register picks shared channel source
// - timer3, audio, video on channels 0-7
// - spi, uart channels; 12,13,24,56-63 reserved
// - gpio, card, i2c on 25-47
// - timers 48-51, pwm 52-55
// - completion or intermediate chains another channel
// - exhausted set reloads from link set
// - increment or constant addressing, separate indexes
// - two 16-entry queues, programmable priority
// - transfer controllers: 64-bit, four outstanding
// - record errors, queue watermark and threshold
//
// The plain strobed port and the register addresses are this design's own decisions.
`default_nettype none
`timescale 1ns/1ps
module dma_channel_ctrl
  import dma_pkg::*;
(
  input  wire logic             CLOCK,
  input  wire logic             SRST,
  input  wire logic [10:0]      ADDR,
  input  wire logic [31:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [31:0]      RDATA,
  input  wire logic [63:0]      EVENTS,
  input  wire logic [1:0]       TIMER2_EVENTS,
  output logic      [1:0]       TC_RD_REQ,
  output logic      [1:0][31:0] TC_RD_ADDR,
  input  wire logic [1:0]       TC_RD_ACK,
  input  wire logic [1:0][63:0] TC_RD_DATA,
  input  wire logic [1:0]       TC_RD_ERR,
  output logic      [1:0]       TC_WR_REQ,
  output logic      [1:0][31:0] TC_WR_ADDR,
  output logic      [1:0][63:0] TC_WR_DATA,
  output logic      [1:0][7:0]  TC_WR_BE,
  input  wire logic [1:0]       TC_WR_ACK,
  output logic      [1:0][2:0]  TC_PRIORITY
);
  localparam int TRW = $bits(tr_t);
  localparam int LW  = $clog2(QUEUE_DEPTH) + 1;

  typedef enum logic {ST_IDLE = 1'b0, ST_LINK = 1'b1} eng_t;
  typedef struct packed {
    logic [63:0]     sync1;
    logic [63:0]     sync2;
    logic [1:0]      alt1;
    logic [1:0]      alt2;
    logic [63:0]     prev;
    logic [63:0]     pending;
    logic [63:0]     enable;
    logic [63:0]     complete;
    logic [7:0]      qpending;
    logic [7:0]      qcomplete;
    logic [7:0][6:0] qmap;
    logic [5:0]      prio;
    logic [1:0]      srcsel;
    logic [2:0]      err;
    logic [1:0][4:0] mark;
    logic [4:0]      thresh;
    logic [1:0]      over;
    logic [31:0]     rdata;
    eng_t            state;
    logic [6:0]      cur_set;
    logic [6:0]      link_set;
    logic [2:0]      wcnt;
  } st_t;

  st_t         s, next_s;
  logic [31:0] mem [NUM_SETS*SET_WORDS];
  logic        mem_we;
  logic [9:0]  mem_wa;
  logic [31:0] mem_wd;

  // per-queue wiring
  logic [1:0]          q_in_valid, q_in_ready, q_out_valid, q_out_ready;
  logic [1:0][TRW-1:0] q_out_data;
  logic [1:0][LW-1:0]  q_level;
  logic [1:0]          tc_done, tc_err;
  logic [1:0][6:0]     tc_tag;
  tr_t                 tr;

  // engine view of the selected descriptor set
  logic [31:0] w [SET_WORDS];
  logic [6:0]  ev_pick, q_pick, set;
  logic        sel_quick, have, go, qsel, ab, last, exhausted, bus_mem_wr;
  logic [15:0] acnt, bcnt, ccnt, curb, curc, nb, nc;
  logic [63:0] muxed, rise;

  // lowest set bit of a vector, bit 6 marks that one was found
  function automatic logic [6:0] first_one(input logic [63:0] v);
    first_one = 7'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) first_one = {1'b1, 6'(i)};
    end
  endfunction

  // bus word address match against one control register address
  function automatic logic is_reg(input logic [10:0] a, input logic [10:0] r);
    is_reg = a == r;
  endfunction

  // event selection and descriptor fetch
  always_comb begin
    bus_mem_wr = WR && ADDR[ADDR_MEM_BIT];
    ev_pick    = first_one(s.pending & s.enable);
    q_pick     = first_one({56'h0, s.qpending});
    sel_quick  = !ev_pick[6] && q_pick[6];
    have       = ev_pick[6] || q_pick[6];
    set = sel_quick ? s.qmap[q_pick[2:0]] : {1'b0, ev_pick[5:0]};
    for (int k = 0; k < SET_WORDS; k++) begin
      w[k] = mem[{set, 3'(k)}];
    end
    ab   = w[W_OPT][OPT_AB];
    qsel = w[W_OPT][OPT_QUEUE];
    acnt = w[W_CNT][15:0];
    bcnt = w[W_CNT][31:16];
    ccnt = w[W_LINK][31:16];
    curb = w[W_PROG][31:16];
    curc = w[W_PROG][15:0];
    exhausted = curc >= ccnt;
    // next position: one array in single mode, one frame in two-dim mode
    if (ab) begin
      nb = '0;
      nc = curc + 16'h0001;
    end else if (curb + 16'h0001 >= bcnt) begin
      nb = '0;
      nc = curc + 16'h0001;
    end else begin
      nb = curb + 16'h0001;
      nc = curc;
    end
    last = nc >= ccnt;
    go   = have && s.state == ST_IDLE && !bus_mem_wr && (exhausted || q_in_ready[qsel]);
    // third dimension kept here: frame offset from the c index
    tr.src = w[W_OPT][OPT_SRC_CONST] ? w[W_SRC] : w[W_SRC]
           + 32'(curc) * 32'(w[W_CIDX][15:0]) + (ab ? 32'h0 : 32'(curb) * 32'(w[W_BIDX][15:0]));
    tr.dst = w[W_OPT][OPT_DST_CONST] ? w[W_DST] : w[W_DST]
           + 32'(curc) * 32'(w[W_CIDX][31:16]) + (ab ? 32'h0 : 32'(curb) * 32'(w[W_BIDX][31:16]));
    tr.acnt      = acnt;
    tr.bcnt      = ab ? bcnt : 16'h0001;
    tr.sbidx     = w[W_BIDX][15:0];
    tr.dbidx     = w[W_BIDX][31:16];
    tr.src_const = w[W_OPT][OPT_SRC_CONST];
    tr.dst_const = w[W_OPT][OPT_DST_CONST];
    tr.tag       = sel_quick ? {1'b1, 3'h0, q_pick[2:0]} : {1'b0, ev_pick[5:0]};
    for (int g = 0; g < NUM_QUEUES; g++) begin
      q_in_valid[g] = go && !exhausted && qsel == 1'(g);
    end
  end

  // event input path: synchronise, pick shared sources, catch rising edges
  always_comb begin
    muxed = s.sync2;
    if (s.srcsel[0]) muxed[CH_MUX_TX] = s.alt2[0];
    if (s.srcsel[1]) muxed[CH_MUX_RX] = s.alt2[1];
    rise = muxed & ~s.prev & ~RESERVED_CH;
  end

  // register file, pending flags and engine state
  always_comb begin
    next_s       = s;
    next_s.sync1 = EVENTS;
    next_s.sync2 = s.sync1;
    next_s.alt1  = TIMER2_EVENTS;
    next_s.alt2  = s.alt1;
    next_s.prev  = muxed;
    next_s.rdata = 32'h0;
    mem_we = 1'b0;
    mem_wa = ADDR[9:0];
    mem_wd = WDATA;
    // software clears first so that hardware sets in the same cycle win
    if (WR && !ADDR[ADDR_MEM_BIT]) begin
      if (is_reg(ADDR, REG_ENABLE_LOW)) next_s.enable[31:0] = WDATA;
      if (is_reg(ADDR, REG_ENABLE_HIGH)) next_s.enable[63:32] = WDATA;
      if (is_reg(ADDR, REG_CLEAR_LOW)) next_s.pending[31:0] = s.pending[31:0] & ~WDATA;
      if (is_reg(ADDR, REG_CLEAR_HIGH)) next_s.pending[63:32] = s.pending[63:32] & ~WDATA;
      if (is_reg(ADDR, REG_DONE_LOW)) next_s.complete[31:0] = s.complete[31:0] & ~WDATA;
      if (is_reg(ADDR, REG_DONE_HIGH)) next_s.complete[63:32] = s.complete[63:32] & ~WDATA;
      if (is_reg(ADDR, REG_QUICK)) next_s.qcomplete = s.qcomplete & ~WDATA[15:8];
      if (is_reg(ADDR, REG_ERROR)) next_s.err = s.err & ~WDATA[2:0];
      if (is_reg(ADDR, REG_QSTATUS)) begin
        next_s.over = s.over & ~WDATA[21:20];
        if (WDATA[22]) next_s.mark = '0;
      end
      if (is_reg(ADDR, REG_PRIORITY)) next_s.prio = WDATA[5:0];
      if (is_reg(ADDR, REG_SRC_SELECT)) next_s.srcsel = WDATA[1:0];
      if (is_reg(ADDR, REG_THRESHOLD)) next_s.thresh = WDATA[4:0];
      if (ADDR[10:3] == REG_QMAP_BASE[10:3]) next_s.qmap[ADDR[2:0]] = WDATA[6:0];
    end
    // engine: submit one request, advance the set, chain and link
    if (go) begin
      if (sel_quick) next_s.qpending[q_pick[2:0]] = 1'b0;
      else next_s.pending[ev_pick[5:0]] = 1'b0;
      if (exhausted) begin
        next_s.err[2] = 1'b1; // trigger on a spent set is dropped and flagged
      end else begin
        mem_we = 1'b1;
        mem_wa = {set, W_PROG};
        mem_wd = {nb, nc};
        if (last ? w[W_OPT][OPT_CHAIN] : w[W_OPT][OPT_ICHAIN])
          next_s.pending[w[W_OPT][OPT_TARGET_LSB +: 6]] = 1'b1;
        if (last && w[W_LINK][15:0] != LINK_NULL) begin
          next_s.state    = ST_LINK;
          next_s.cur_set  = set;
          next_s.link_set = w[W_LINK][6:0];
          next_s.wcnt     = '0;
        end
      end
    end
    // link reload copies one word per cycle, yielding to bus writes
    if (s.state == ST_LINK && !bus_mem_wr) begin
      mem_we      = 1'b1;
      mem_wa      = {s.cur_set, s.wcnt};
      mem_wd      = mem[{s.link_set, s.wcnt}];
      next_s.wcnt = s.wcnt + 3'h1;
      if (s.wcnt == 3'h7) next_s.state = ST_IDLE;
    end
    // descriptor writes from the config port win the single write port
    if (bus_mem_wr) begin
      mem_we = 1'b1;
      mem_wa = ADDR[9:0];
      mem_wd = WDATA;
      if (ADDR[2:0] == TRIGGER_WORD) begin
        for (int q = 0; q < NUM_QCH; q++) begin
          if (s.qmap[q] == ADDR[9:3]) next_s.qpending[q] = 1'b1;
        end
      end
    end
    // hardware and software event sets, latched regardless of enable
    next_s.pending = next_s.pending | rise;
    if (WR && is_reg(ADDR, REG_SET_LOW))
      next_s.pending[31:0] = next_s.pending[31:0] | WDATA;
    if (WR && is_reg(ADDR, REG_SET_HIGH))
      next_s.pending[63:32] = next_s.pending[63:32] | WDATA;
    // completion and error reports from the transfer controllers
    for (int g = 0; g < NUM_QUEUES; g++) begin
      if (tc_done[g]) begin
        if (tc_tag[g][6]) next_s.qcomplete[tc_tag[g][2:0]] = 1'b1;
        else next_s.complete[tc_tag[g][5:0]] = 1'b1;
      end
      if (tc_err[g]) next_s.err[g] = 1'b1;
      if (5'(q_level[g]) > next_s.mark[g]) next_s.mark[g] = 5'(q_level[g]);
      if (s.thresh != '0 && 5'(q_level[g]) >= s.thresh) next_s.over[g] = 1'b1;
    end
    // read data stands only in the cycle after the strobe
    if (RD) begin
      if (ADDR[ADDR_MEM_BIT]) next_s.rdata = mem[ADDR[9:0]];
      else if (is_reg(ADDR, REG_PEND_LOW)) next_s.rdata = s.pending[31:0];
      else if (is_reg(ADDR, REG_PEND_HIGH)) next_s.rdata = s.pending[63:32];
      else if (is_reg(ADDR, REG_ENABLE_LOW)) next_s.rdata = s.enable[31:0];
      else if (is_reg(ADDR, REG_ENABLE_HIGH)) next_s.rdata = s.enable[63:32];
      else if (is_reg(ADDR, REG_DONE_LOW)) next_s.rdata = s.complete[31:0];
      else if (is_reg(ADDR, REG_DONE_HIGH)) next_s.rdata = s.complete[63:32];
      else if (is_reg(ADDR, REG_QUICK)) next_s.rdata = {16'h0, s.qcomplete, s.qpending};
      else if (is_reg(ADDR, REG_PRIORITY)) next_s.rdata = {26'h0, s.prio};
      else if (is_reg(ADDR, REG_SRC_SELECT)) next_s.rdata = {30'h0, s.srcsel};
      else if (is_reg(ADDR, REG_ERROR)) next_s.rdata = {29'h0, s.err};
      else if (is_reg(ADDR, REG_THRESHOLD)) next_s.rdata = {27'h0, s.thresh};
      else if (is_reg(ADDR, REG_QSTATUS))
        next_s.rdata = {10'h0, s.over, s.mark[1], s.mark[0], 5'(q_level[1]), 5'(q_level[0])};
      else if (ADDR[10:3] == REG_QMAP_BASE[10:3]) next_s.rdata = {25'h0, s.qmap[ADDR[2:0]]};
    end
    // synchronous reset
    if (SRST) begin
      next_s        = '0;
      next_s.prio   = RST_PRIORITY;
      next_s.thresh = RST_THRESHOLD;
      for (int q = 0; q < NUM_QCH; q++) begin
        next_s.qmap[q] = RST_QMAP_BASE + 7'(q);
      end
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    s <= next_s;
  end

  // descriptor memory, one write port shared by bus, engine and link reload
  always_ff @(posedge CLOCK) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  // two event queues, each feeding its own transfer controller
  generate
    for (genvar g = 0; g < NUM_QUEUES; g++) begin : g_path
      // queue entries hold the request flattened to plain bits
      tr_t tr_head;
      assign tr_head = tr_t'(q_out_data[g]);
      dma_event_queue #(.W(TRW), .DEPTH(QUEUE_DEPTH)) u_queue (
        .clock     (CLOCK),
        .srst      (SRST),
        .in_valid  (q_in_valid[g]),
        .in_ready  (q_in_ready[g]),
        .in_data   (TRW'(tr)),
        .out_valid (q_out_valid[g]),
        .out_ready (q_out_ready[g]),
        .out_data  (q_out_data[g]),
        .level     (q_level[g])
      );
      dma_transfer_ctrl #(.SLOTS(TC_OUTSTANDING)) u_tc (
        .clock    (CLOCK),
        .srst     (SRST),
        .tr_valid (q_out_valid[g]),
        .tr_ready (q_out_ready[g]),
        .tr_in    (tr_head),
        .rd_req   (TC_RD_REQ[g]),
        .rd_addr  (TC_RD_ADDR[g]),
        .rd_ack   (TC_RD_ACK[g]),
        .rd_data  (TC_RD_DATA[g]),
        .rd_err   (TC_RD_ERR[g]),
        .wr_req   (TC_WR_REQ[g]),
        .wr_addr  (TC_WR_ADDR[g]),
        .wr_data  (TC_WR_DATA[g]),
        .wr_be    (TC_WR_BE[g]),
        .wr_ack   (TC_WR_ACK[g]),
        .done     (tc_done[g]),
        .done_tag (tc_tag[g]),
        .err      (tc_err[g])
      );
      assign TC_PRIORITY[g] = s.prio[3*g +: 3];
    end
  endgenerate

  // read data register reads zero outside the cycle after a read strobe
  assign RDATA = s.rdata;
endmodule
`default_nettype wire

// >>> dma_channel_ctrl_assertions.sv
// bus and transfer controller checks of the channel controller
`timescale 1ns/1ps
`default_nettype none
module dma_chk
  import dma_pkg::*;
(
  input wire logic             CLOCK,
  input wire logic             SRST,
  input wire logic [10:0]      ADDR,
  input wire logic [31:0]      WDATA,
  input wire logic             WR,
  input wire logic             RD,
  input wire logic [31:0]      RDATA,
  input wire logic [1:0]       TC_RD_REQ,
  input wire logic [1:0][31:0] TC_RD_ADDR,
  input wire logic [1:0]       TC_RD_ACK,
  input wire logic [1:0]       TC_WR_REQ,
  input wire logic [1:0][63:0] TC_WR_DATA,
  input wire logic [1:0]       TC_WR_ACK,
  input wire logic [1:0][2:0]  TC_PRIORITY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // steps of a beat and of a register access
  sequence rd_beat; TC_RD_REQ[0] && TC_RD_ACK[0]; endsequence
  sequence en_write; WR && ADDR == REG_ENABLE_LOW; endsequence
  sequence en_read; RD && ADDR == REG_ENABLE_LOW; endsequence
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("stray read data");
  prio_reset_a: assert property ($past(SRST) |-> TC_PRIORITY == {3'h1, 3'h0})
    else $error("priority reset value");
  prio_write_a: assert property (WR && ADDR == REG_PRIORITY |=>
    TC_PRIORITY == $past(WDATA[5:0])) else $error("priority not written");
  rd_hold_a: assert property (TC_RD_REQ[0] && !TC_RD_ACK[0] |=>
    TC_RD_REQ[0] && $stable(TC_RD_ADDR[0])) else $error("read request dropped");
  wr_hold_a: assert property (TC_WR_REQ[0] && !TC_WR_ACK[0] |=>
    TC_WR_REQ[0] && $stable(TC_WR_DATA[0])) else $error("write request dropped");
  rd_to_wr_a: assert property (rd_beat |=> TC_WR_REQ[0])
    else $error("no write after read");
  req_excl_a: assert property (!(TC_RD_REQ[0] && TC_WR_REQ[0]))
    else $error("read and write");
  en_readback_a: assert property (en_write ##2 en_read |=> RDATA == $past(WDATA, 3))
    else $error("enable readback");
endmodule
bind dma_channel_ctrl dma_chk dma_chk_i (.*);
`default_nettype wire

// >>> dma_event_queue.sv
// event queue holding pending transfer requests in arrival order
`default_nettype none
`timescale 1ns/1ps
module dma_event_queue #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic      [W-1:0]               out_data,
  output logic      [$clog2(DEPTH):0]     level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } q_t;
  q_t         s, next_s;
  logic [W-1:0] store [DEPTH];
  logic       push, pop;

  // handshakes and pointer update
  always_comb begin
    in_ready  = s.cnt != (AW+1)'(DEPTH);
    out_valid = s.cnt != '0;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_s    = s;
    if (push) next_s.wp = s.wp + 1'b1;
    if (pop) next_s.rp = s.rp + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (srst) next_s = '0;
  end

  always_ff @(posedge clock) begin
    s <= next_s;
    if (push) store[s.wp] <= in_data;
  end

  assign out_data = store[s.rp];
  assign level    = s.cnt;
endmodule
`default_nettype wire

// >>> dma_mem_model.sv
// memory slave answering the read and write beats of both controllers
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             hold,
  input  wire logic             fail,
  input  wire logic [1:0]       rd_req,
  input  wire logic [1:0][31:0] rd_addr,
  output logic      [1:0]       rd_ack,
  output logic      [1:0][63:0] rd_data,
  output logic      [1:0]       rd_err,
  input  wire logic [1:0]       wr_req,
  output logic      [1:0]       wr_ack
);
  logic [63:0] noise;
  // one-cycle acks, held back while hold is high
  always_ff @(posedge clock) begin
    noise <= srst ? 64'h0 : {noise[62:0], ~noise[63]};
    rd_ack <= srst ? 2'b00 : rd_req & ~rd_ack & {2{~hold}};
    wr_ack <= srst ? 2'b00 : wr_req & ~wr_ack & {2{~hold}};
  end
  // data valid only with the ack, a changing pattern elsewhere
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      rd_data[g] = rd_ack[g] ? {~rd_addr[g], rd_addr[g]} : noise;
      rd_err[g] = rd_ack[g] & fail;
    end
  end
endmodule
`default_nettype wire

// >>> dma_pkg.sv
// shared constants and types of the dma channel and transfer controllers
`default_nettype none
package dma_pkg;
  localparam int NUM_EVT_CH     = 64;
  localparam int NUM_QCH        = 8;
  localparam int NUM_SETS       = 128;
  localparam int SET_WORDS      = 8;
  localparam int NUM_QUEUES     = 2;
  localparam int QUEUE_DEPTH    = 16;
  localparam int TC_OUTSTANDING = 4;
  localparam logic [15:0] BEAT_BYTES = 16'h0008;
  // register word addresses; address bit 10 selects descriptor memory
  localparam int          ADDR_MEM_BIT    = 10;
  localparam logic [10:0] REG_PEND_LOW    = 11'h000;
  localparam logic [10:0] REG_PEND_HIGH   = 11'h001;
  localparam logic [10:0] REG_ENABLE_LOW  = 11'h002;
  localparam logic [10:0] REG_ENABLE_HIGH = 11'h003;
  localparam logic [10:0] REG_SET_LOW     = 11'h004;
  localparam logic [10:0] REG_SET_HIGH    = 11'h005;
  localparam logic [10:0] REG_CLEAR_LOW   = 11'h006;
  localparam logic [10:0] REG_CLEAR_HIGH  = 11'h007;
  localparam logic [10:0] REG_QMAP_BASE   = 11'h008;
  localparam logic [10:0] REG_PRIORITY    = 11'h010;
  localparam logic [10:0] REG_SRC_SELECT  = 11'h011;
  localparam logic [10:0] REG_QSTATUS     = 11'h012;
  localparam logic [10:0] REG_ERROR       = 11'h013;
  localparam logic [10:0] REG_DONE_LOW    = 11'h014;
  localparam logic [10:0] REG_DONE_HIGH   = 11'h015;
  localparam logic [10:0] REG_QUICK       = 11'h016;
  localparam logic [10:0] REG_THRESHOLD   = 11'h017;
  // descriptor word indexes and option bits
  localparam logic [2:0] W_OPT = 3'h0, W_SRC = 3'h1, W_CNT = 3'h2, W_DST = 3'h3;
  localparam logic [2:0] W_BIDX = 3'h4, W_LINK = 3'h5, W_CIDX = 3'h6, W_PROG = 3'h7;
  localparam logic [2:0] TRIGGER_WORD = W_PROG;
  localparam int OPT_AB = 0, OPT_SRC_CONST = 1, OPT_DST_CONST = 2, OPT_QUEUE = 3;
  localparam int OPT_CHAIN = 4, OPT_ICHAIN = 5, OPT_TARGET_LSB = 8;
  localparam logic [15:0] LINK_NULL = 16'hffff;
  // fixed event wiring: channels with no source, and the two shared channels
  localparam logic [63:0] RESERVED_CH = 64'hff00_0000_0100_3000;
  localparam int CH_MUX_TX = 8, CH_MUX_RX = 9;
  // reset values
  localparam logic [6:0] RST_QMAP_BASE = 7'h40;
  localparam logic [5:0] RST_PRIORITY  = 6'h08;
  localparam logic [4:0] RST_THRESHOLD = 5'h10;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic        src_const;
    logic        dst_const;
    logic [6:0]  tag;
  } tr_t;
endpackage
`default_nettype wire

// >>> dma_transfer_ctrl.sv
// transfer controller: walks two dimensions with 64-bit read and write beats
`default_nettype none
`timescale 1ns/1ps
module dma_transfer_ctrl
  import dma_pkg::*;
#(
  parameter int SLOTS = TC_OUTSTANDING
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        tr_valid,
  output logic             tr_ready,
  input  wire tr_t         tr_in,
  output logic             rd_req,
  output logic      [31:0] rd_addr,
  input  wire logic        rd_ack,
  input  wire logic [63:0] rd_data,
  input  wire logic        rd_err,
  output logic             wr_req,
  output logic      [31:0] wr_addr,
  output logic      [63:0] wr_data,
  output logic      [7:0]  wr_be,
  input  wire logic        wr_ack,
  output logic             done,
  output logic      [6:0]  done_tag,
  output logic             err
);
  localparam int SW = $clog2(SLOTS);
  typedef enum logic [1:0] {T_IDLE = 2'b00, T_READ = 2'b01, T_WRITE = 2'b10} ph_t;
  typedef struct packed {
    logic [SW-1:0] wp;
    logic [SW-1:0] rp;
    logic [SW:0]   cnt;
    ph_t           ph;
    logic [15:0]   a_off;
    logic [15:0]   b;
    logic [63:0]   data;
    logic          done;
    logic [6:0]    done_tag;
    logic          err;
  } tc_t;
  tc_t   s, next_s;
  tr_t   slot [SLOTS];
  tr_t   cur;
  logic  push, pop;
  logic [15:0] rem;

  // request intake, beat sequencing and address generation
  always_comb begin
    cur      = slot[s.rp];
    tr_ready = s.cnt != (SW+1)'(SLOTS);
    push     = tr_valid && tr_ready;
    pop      = 1'b0;
    next_s   = s;
    next_s.done = 1'b0;
    next_s.err  = 1'b0;
    unique case (s.ph)
      T_IDLE: if (s.cnt != '0) begin
        next_s.ph    = T_READ;
        next_s.a_off = '0;
        next_s.b     = '0;
      end
      T_READ: if (rd_ack) begin
        next_s.data = rd_data;
        next_s.err  = rd_err;
        next_s.ph   = T_WRITE;
      end
      T_WRITE: if (wr_ack) begin
        next_s.ph = T_READ;
        if (s.a_off + BEAT_BYTES >= cur.acnt) begin
          next_s.a_off = '0;
          next_s.b     = s.b + 16'h0001;
          if (s.b + 16'h0001 >= cur.bcnt) begin
            next_s.ph       = T_IDLE;
            pop             = 1'b1;
            next_s.done     = 1'b1;
            next_s.done_tag = cur.tag;
          end
        end else begin
          next_s.a_off = s.a_off + BEAT_BYTES;
        end
      end
      default: next_s.ph = T_IDLE;
    endcase
    if (push) next_s.wp = s.wp + 1'b1;
    if (pop) next_s.rp = s.rp + 1'b1;
    next_s.cnt = s.cnt + (SW+1)'(push) - (SW+1)'(pop);
    if (srst) next_s = '0;
  end

  always_ff @(posedge clock) begin
    s <= next_s;
    if (push) slot[s.wp] <= tr_in;
  end

  // constant mode holds the address; increment mode adds array and beat offsets
  always_comb begin
    rd_addr = cur.src_const ? cur.src
            : cur.src + 32'(s.b) * 32'(cur.sbidx) + 32'(s.a_off);
    wr_addr = cur.dst_const ? cur.dst
            : cur.dst + 32'(s.b) * 32'(cur.dbidx) + 32'(s.a_off);
    rem     = cur.acnt - s.a_off;
    wr_be   = (rem >= BEAT_BYTES) ? 8'hff : 8'(8'hff >> (4'h8 - rem[3:0]));
  end

  assign rd_req   = s.ph == T_READ;
  assign wr_req   = s.ph == T_WRITE;
  assign wr_data  = s.data;
  assign done     = s.done;
  assign done_tag = s.done_tag;
  assign err      = s.err;
endmodule
`default_nettype wire

// >>> tb_dma_channel_ctrl.sv
// self-checking bench of the dma channel controller
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_ctrl;
  import dma_pkg::*;
  logic             CLOCK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, hold = 1'b0, fail = 1'b0;
  logic [10:0]      ADDR = 11'h0;
  logic [31:0]      WDATA = 32'h0, RDATA;
  logic [63:0]      EVENTS = 64'h0;
  logic [1:0]       rd_req, rd_ack, rd_err, wr_req, wr_ack;
  logic [1:0][31:0] rd_addr, wr_addr;
  logic [1:0][63:0] rd_data, wr_data;
  logic [1:0][7:0]  wr_be;
  int               failures = 0, n_compared = 0, cycles = 0;
  logic [40:0]      rdq[$], wrq[$];
  logic [63:0]      wdq[$];
  dma_channel_ctrl dma_channel_ctrl_i (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .EVENTS(EVENTS), .TIMER2_EVENTS(2'b00),
    .TC_RD_REQ(rd_req), .TC_RD_ADDR(rd_addr), .TC_RD_ACK(rd_ack), .TC_RD_DATA(rd_data),
    .TC_RD_ERR(rd_err), .TC_WR_REQ(wr_req), .TC_WR_ADDR(wr_addr), .TC_WR_DATA(wr_data),
    .TC_WR_BE(wr_be), .TC_WR_ACK(wr_ack), .TC_PRIORITY());
  dma_mem_model dma_mem_model_i (.clock(CLOCK), .srst(SRST), .hold(hold), .fail(fail),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .rd_err(rd_err),
    .wr_req(wr_req), .wr_ack(wr_ack));
  initial forever #20 CLOCK = ~CLOCK;
  // log finished beats and cut a hang short
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    for (int g = 0; g < 2; g++) begin
      if (rd_req[g] && rd_ack[g]) rdq.push_back({8'h0, g[0], rd_addr[g]});
      if (wr_req[g] && wr_ack[g]) begin
        wrq.push_back({wr_be[g], g[0], wr_addr[g]});
        wdq.push_back(wr_data[g]);
      end
    end
    if (cycles == 4000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic bus(input logic w, input logic r, input logic [10:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= d;
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [10:0] a, input logic [31:0] want);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, a, 32'h0);
    #1 chk(RDATA, want);
  endtask
  // one descriptor set, one pass, no link; progress word last
  task automatic prog(input logic [6:0] s, input logic [31:0] o, sa, cnt, da, idx);
    logic [31:0] w[8];
    w = '{o, sa, cnt, da, idx, 32'h0001_ffff, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) wr({1'b1, s, i[2:0]}, w[i]);
  endtask
  task automatic s_reset;
    rd(REG_ENABLE_LOW, 32'h0);
    rd(REG_PRIORITY, 32'h8);
    rd(REG_QMAP_BASE, 32'h40);
    rd(REG_THRESHOLD, 32'h10);
  endtask
  // disabled event latches, then one array per event or set bit
  task automatic s_event;
    prog(7'h03, 32'h0, 32'h100, 32'h0002_0008, 32'h200, 32'h0010_0010);
    EVENTS[3] <= 1'b1;
    idle(6);
    rd(REG_PEND_LOW, 32'h8);
    chk(rdq.size(), 0);
    wr(REG_ENABLE_LOW, 32'h8);
    rd(REG_ENABLE_LOW, 32'h8);
    idle(30);
    chk(rdq.size(), 1);
    chk(rdq[0], 41'h100);
    chk(wrq[0], {8'hff, 33'h200});
    chk(wdq[0], {~32'h100, 32'h100});
    wr(REG_SET_LOW, 32'h8);
    idle(30);
    chk(rdq[1], 41'h110);
    chk(wrq[1], {8'hff, 33'h210});
    rd(REG_DONE_LOW, 32'h8);
  endtask
  // remapped quick channel on queue 1, a whole frame, slow failing memory
  task automatic s_quick;
    wr(REG_QMAP_BASE, 32'h50);
    wr(REG_PRIORITY, 32'h5);
    hold <= 1'b1;
    fail <= 1'b1;
    prog(7'h50, 32'h9, 32'h300, 32'h0002_0008, 32'h500, 32'h0008_0008);
    idle(8);
    hold <= 1'b0;
    idle(40);
    chk(rdq.size(), 4);
    chk(rdq[2], {9'h1, 32'h300});
    chk(rdq[3], {9'h1, 32'h308});
    chk(wrq[3], {8'hff, 1'b1, 32'h508});
    rd(REG_PRIORITY, 32'h5);
    rd(REG_QUICK, 32'h100);
    rd(REG_ERROR, 32'h2);
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    idle(12);
    SRST <= 1'b0;
    idle(3);
    s_reset();
    s_event();
    s_quick();
    conclude();
  end
endmodule
`default_nettype wire
